// ---- logic/canfd_cfg_pkg.sv ----
// Shared constants and types for the CAN FD receive FIFO and bit timing configuration
package canfd_cfg_pkg;
  localparam int NUM_TXMB = 4;
  localparam int NUM_ERR  = 5;
  localparam int TIM_W    = 11;
  localparam int CNT_W    = 6;

  // Error cause bit positions
  localparam int ERR_WARN    = 0;
  localparam int ERR_PASSIVE = 1;
  localparam int ERR_BO_IN   = 2;
  localparam int ERR_BO_OUT  = 3;
  localparam int ERR_OVLD    = 4;

  // Receive FIFO and delay compensation reset values
  localparam logic       FIFO_EN_DEF    = 1'b0;
  localparam logic       IRQ_EN_DEF     = 1'b1;
  localparam logic       IRQ_EVERY_DEF  = 1'b1;
  localparam logic [2:0] THRESH_DEF     = 3'h3;
  localparam logic [2:0] DEPTH_DEF      = 3'h3;
  localparam logic [2:0] PAYLOAD_DEF    = 3'h7;
  localparam logic       TDC_EN_DEF     = 1'b1;

  // Depth codes and entry counts, and the full threshold code
  localparam logic [2:0] DEPTH_4  = 3'h1;
  localparam logic [2:0] DEPTH_8  = 3'h2;
  localparam logic [2:0] DEPTH_16 = 3'h3;
  localparam logic [2:0] DEPTH_32 = 3'h4;
  localparam logic [2:0] DEPTH_48 = 3'h5;
  localparam logic [CNT_W-1:0] CAP_4  = 6'h04;
  localparam logic [CNT_W-1:0] CAP_8  = 6'h08;
  localparam logic [CNT_W-1:0] CAP_16 = 6'h10;
  localparam logic [CNT_W-1:0] CAP_32 = 6'h20;
  localparam logic [CNT_W-1:0] CAP_48 = 6'h30;
  localparam logic [2:0] THRESH_FULL = 3'h7;

  // Bit timing limits and reset values
  localparam logic [TIM_W-1:0] BRP_MIN      = 11'h001;
  localparam logic [TIM_W-1:0] BRP_MAX      = 11'h400;
  localparam logic [TIM_W-1:0] NOM_BRP_DEF  = 11'h001;
  localparam logic [TIM_W-1:0] NOM_TS1_MIN  = 11'h002;
  localparam logic [TIM_W-1:0] NOM_TS1_MAX  = 11'h100;
  localparam logic [TIM_W-1:0] NOM_TS1_DEF  = 11'h014;
  localparam logic [TIM_W-1:0] NOM_TS2_MIN  = 11'h002;
  localparam logic [TIM_W-1:0] NOM_TS2_MAX  = 11'h080;
  localparam logic [TIM_W-1:0] NOM_TS2_DEF  = 11'h00a;
  localparam logic [TIM_W-1:0] NOM_SJW_MIN  = 11'h001;
  localparam logic [TIM_W-1:0] NOM_SJW_MAX  = 11'h080;
  localparam logic [TIM_W-1:0] NOM_SJW_DEF  = 11'h004;
  localparam logic [TIM_W-1:0] DAT_BRP_DEF  = 11'h001;
  localparam logic [TIM_W-1:0] DAT_TS1_MIN  = 11'h002;
  localparam logic [TIM_W-1:0] DAT_TS1_MAX  = 11'h020;
  localparam logic [TIM_W-1:0] DAT_TS1_DEF  = 11'h005;
  localparam logic [TIM_W-1:0] DAT_TS2_MIN  = 11'h002;
  localparam logic [TIM_W-1:0] DAT_TS2_MAX  = 11'h010;
  localparam logic [TIM_W-1:0] DAT_TS2_DEF  = 11'h002;
  localparam logic [TIM_W-1:0] DAT_SJW_MIN  = 11'h001;
  localparam logic [TIM_W-1:0] DAT_SJW_MAX  = 11'h010;
  localparam logic [TIM_W-1:0] DAT_SJW_DEF  = 11'h001;

  typedef enum logic [1:0] {
    IRQ_OFF       = 2'b00,
    IRQ_THRESHOLD = 2'b01,
    IRQ_EVERY     = 2'b11
  } fifo_irq_mode_t;
endpackage

// ---- logic/bit_timing_if.sv ----
// Bit timing parameters and quantum strobes between the config block and the bit timer
interface bit_timing_if;
  import canfd_cfg_pkg::*;
  logic [TIM_W-1:0] brp;
  logic [TIM_W-1:0] tseg1;
  logic [TIM_W-1:0] tseg2;
  logic [TIM_W-1:0] sjw;
  logic             resync;
  logic             tqTick;
  logic             bitStart;
  logic             samplePoint;
  modport cfg (output brp, tseg1, tseg2, sjw, resync, input tqTick, bitStart, samplePoint);
  modport timer (input brp, tseg1, tseg2, sjw, resync, output tqTick, bitStart, samplePoint);
endinterface

// ---- logic/bit_timer.sv ----
// Time quantum prescaler and bit time sequencer
module bit_timer
  import canfd_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Timing parameters and strobes
  bit_timing_if.timer bt
);
  logic [TIM_W-1:0] prescCnt;
  logic [TIM_W:0]   tqCnt;
  logic [TIM_W:0]   stretch;
  logic [TIM_W:0]   bitLen;
  logic [TIM_W:0]   sampleAt;
  logic             lastPresc;

  // One sync quantum, then both segments, plus any lengthening from resync
  assign bitLen    = 12'h001 + {1'b0, bt.tseg1} + {1'b0, bt.tseg2} + stretch; // see R19
  assign sampleAt  = {1'b0, bt.tseg1} + stretch;
  assign lastPresc = (prescCnt >= bt.brp - 11'h001);

  always_ff @(posedge clock) begin
    if (rst || bt.resync || lastPresc) begin
      prescCnt  <= 11'h000; // see R19
    end else begin
      prescCnt  <= prescCnt + 11'h001;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      bt.tqTick <= 1'b0;
    end else begin
      bt.tqTick <= lastPresc && !bt.resync;
    end
  end

  // Late edge lengthens segment 1, early edge in segment 2 shortens the bit
  always_ff @(posedge clock) begin
    if (rst) begin
      tqCnt          <= 12'h000;
      stretch        <= 12'h000;
      bt.bitStart    <= 1'b0;
      bt.samplePoint <= 1'b0;
    end else begin
      bt.bitStart    <= 1'b0;
      bt.samplePoint <= 1'b0;
      if (bt.resync && tqCnt != 12'h000 && tqCnt <= sampleAt) begin
        stretch <= (tqCnt < {1'b0, bt.sjw}) ? tqCnt : {1'b0, bt.sjw};
      end else if (bt.resync && bitLen - tqCnt <= {1'b0, bt.sjw}) begin
        tqCnt       <= 12'h000;
        stretch     <= 12'h000;
        bt.bitStart <= 1'b1;
      end else if (lastPresc) begin
        if (tqCnt + 12'h001 >= bitLen) begin
          tqCnt       <= 12'h000;
          stretch     <= 12'h000;
          bt.bitStart <= 1'b1; // see R19
        end else begin
          tqCnt <= tqCnt + 12'h001;
        end
        bt.samplePoint <= (tqCnt == sampleAt);
      end
    end
  end
endmodule

// ---- logic/canfd_rx_fifo_timing_config.sv ----
// Receive FIFO 1 control, interrupt gating and bit timing configuration of a CAN FD channel
// Notes on behaviour
// R1: Threshold code 0..6 means one to seven eighths, code 7 full; default half.
// R2: Threshold matters only in threshold interrupt mode.
// R3: Depth codes 1..5 give 4, 8, 16, 32, 48 entries; default 16.
// R4: Payload code 0..7 gives 8 to 64 bytes; default 64.
// R5: Interrupt modes: off, at threshold, every frame (default).
// R6: Threshold interrupt fires only when a new frame crosses the threshold.
// R7: FIFO disabled by default; frames accepted only while enabled.
// R8: Four transmit buffers each gate a completion interrupt; all off by default.
// R9: Warning level raises error interrupt only when enabled; default off.
// R10: Error passive entry raises error interrupt only when enabled; default off.
// R11: Bus-off entry raises error interrupt only when enabled; default off.
// R12: Bus-off recovery raises error interrupt only when enabled; default off.
// R13: Overload raises error interrupt only when enabled; default off.
// R14: Nominal prescaler 1..1024, default 1.
// R15: Nominal segment 1 2..256 (20), segment 2 2..128 (10), jump 1..128 (4).
// R16: Data prescaler 1..1024, segments 2..32 and 2..16, jump 1..16; defaults 1,5,2,1.
// R17: Delay compensation, on by default, measures transmit to receive loop delay.
// R18: Software keeps data prescaler at 2 or less with delay compensation on.
// R19: Bit time is one sync quantum plus both segments, quantum is prescaler cycles.
module canfd_rx_fifo_timing_config
  import canfd_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic                            clock,
  input  wire logic                            rst,
  // Configuration, taken on cfgLoad
  input  wire logic                            cfgLoad,
  input  wire logic                            rxFifoEnable,
  input  wire logic [2:0]                      fifoDepthCode,
  input  wire logic [2:0]                      payloadCode,
  input  wire logic [2:0]                      fifoThresholdCode,
  input  wire logic                            rxFifoIrqEnable,
  input  wire logic                            rxFifoIrqEveryFrame,
  input  wire logic [canfd_cfg_pkg::NUM_TXMB-1:0] txDoneIrqEnable,
  input  wire logic                            warningIrqEnable,
  input  wire logic                            passiveIrqEnable,
  input  wire logic                            busoffEntryIrqEnable,
  input  wire logic                            busoffRecoverIrqEnable,
  input  wire logic                            overloadIrqEnable,
  input  wire logic [canfd_cfg_pkg::TIM_W-1:0] nomBrp,
  input  wire logic [canfd_cfg_pkg::TIM_W-1:0] nomTseg1,
  input  wire logic [canfd_cfg_pkg::TIM_W-1:0] nomTseg2,
  input  wire logic [canfd_cfg_pkg::TIM_W-1:0] nomSjw,
  input  wire logic [canfd_cfg_pkg::TIM_W-1:0] dataBrp,
  input  wire logic [canfd_cfg_pkg::TIM_W-1:0] dataTseg1,
  input  wire logic [canfd_cfg_pkg::TIM_W-1:0] dataTseg2,
  input  wire logic [canfd_cfg_pkg::TIM_W-1:0] dataSjw,
  input  wire logic                            delayCompEnable,
  // Channel events
  input  wire logic                            rxFrame,
  input  wire logic                            rxPop,
  input  wire logic [canfd_cfg_pkg::NUM_TXMB-1:0] txDone,
  input  wire logic [canfd_cfg_pkg::NUM_ERR-1:0]  errEvent,
  // Bit stream
  input  wire logic                            dataPhase,
  input  wire logic                            resync,
  input  wire logic                            txBit,
  input  wire logic                            rxBit,
  // FIFO status and interrupts
  output logic [canfd_cfg_pkg::CNT_W-1:0]      fifoLevel,
  output logic [canfd_cfg_pkg::CNT_W-1:0]      fifoCapacity,
  output logic [6:0]                           payloadBytes,
  output logic                                 frameAccepted,
  output logic                                 frameDropped,
  output logic                                 fifoIrq,
  output logic [canfd_cfg_pkg::NUM_TXMB-1:0]   txDoneIrq,
  output logic                                 errorIrq,
  output logic [canfd_cfg_pkg::NUM_ERR-1:0]    errorCause,
  // Timing strobes and delay compensation
  output logic                                 tqTick,
  output logic                                 bitStart,
  output logic                                 samplePoint,
  output logic [canfd_cfg_pkg::TIM_W-1:0]      tdcDelay,
  output logic [15:0]                          tdcSamplePos
);
  import canfd_cfg_pkg::*;

  function automatic logic [TIM_W-1:0] clampVal(input logic [TIM_W-1:0] v,
                                                input logic [TIM_W-1:0] lo,
                                                input logic [TIM_W-1:0] hi);
    clampVal = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Unlisted depth codes fall back to the default size
  function automatic logic [CNT_W-1:0] capacityOf(input logic [2:0] code);
    unique case (code)
      DEPTH_4:  capacityOf = CAP_4;
      DEPTH_8:  capacityOf = CAP_8;
      DEPTH_32: capacityOf = CAP_32;
      DEPTH_48: capacityOf = CAP_48;
      default:  capacityOf = CAP_16;
    endcase
  endfunction

  function automatic logic [6:0] payloadOf(input logic [2:0] code);
    unique case (code)
      3'h0: payloadOf = 7'h08;
      3'h1: payloadOf = 7'h0c;
      3'h2: payloadOf = 7'h10;
      3'h3: payloadOf = 7'h14;
      3'h4: payloadOf = 7'h18;
      3'h5: payloadOf = 7'h20;
      3'h6: payloadOf = 7'h30;
      3'h7: payloadOf = 7'h40;
    endcase
  endfunction

  // Rounds up so small FIFOs never get a zero threshold
  function automatic logic [CNT_W-1:0] thresholdOf(input logic [CNT_W-1:0] cap,
                                                   input logic [2:0]       code);
    logic [9:0] prod;
    prod = 10'h000;
    if (code == THRESH_FULL) begin
      thresholdOf = cap;
    end else begin
      prod        = {4'h0, cap} * {7'h00, code + 3'h1} + 10'h007;
      thresholdOf = prod[8:3];
    end
  endfunction

  logic                 fifoEn;
  logic [2:0]           depthCode;
  logic [2:0]           payCode;
  logic [2:0]           threshCode;
  fifo_irq_mode_t       irqMode;
  logic [NUM_TXMB-1:0]  txIrqEn;
  logic [NUM_ERR-1:0]   errIrqEn;
  logic                 tdcEn;
  logic [TIM_W-1:0]     nBrp, nTs1, nTs2, nSjw;
  logic [TIM_W-1:0]     dBrp, dTs1, dTs2, dSjw;
  logic [CNT_W-1:0]     thresholdLevel;
  logic                 accept;
  logic                 popOk;
  logic [CNT_W-1:0]     next_level;

  // Configuration registers with documented reset values
  always_ff @(posedge clock) begin
    if (rst) begin
      fifoEn     <= FIFO_EN_DEF; // see R7
      depthCode  <= DEPTH_DEF; // see R3
      payCode    <= PAYLOAD_DEF; // see R4
      threshCode <= THRESH_DEF; // see R1
      irqMode    <= IRQ_EVERY; // see R5
      txIrqEn    <= '0; // see R8
      errIrqEn   <= '0;
      tdcEn      <= TDC_EN_DEF; // see R17
    end else if (cfgLoad) begin
      fifoEn     <= rxFifoEnable;
      depthCode  <= fifoDepthCode;
      payCode    <= payloadCode;
      threshCode <= fifoThresholdCode;
      // Mode bit alone without the enable still means off
      irqMode    <= !rxFifoIrqEnable ? IRQ_OFF : (rxFifoIrqEveryFrame ? IRQ_EVERY : IRQ_THRESHOLD); // see R5
      txIrqEn    <= txDoneIrqEnable;
      errIrqEn   <= {overloadIrqEnable, busoffRecoverIrqEnable, busoffEntryIrqEnable,
                     passiveIrqEnable, warningIrqEnable};
      tdcEn      <= delayCompEnable;
    end
  end

  // Out of range settings are pulled to the nearest legal value
  always_ff @(posedge clock) begin
    if (rst) begin
      nBrp <= NOM_BRP_DEF; // see R14
      nTs1 <= NOM_TS1_DEF; // see R15
      nTs2 <= NOM_TS2_DEF;
      nSjw <= NOM_SJW_DEF;
      dBrp <= DAT_BRP_DEF; // see R16
      dTs1 <= DAT_TS1_DEF;
      dTs2 <= DAT_TS2_DEF;
      dSjw <= DAT_SJW_DEF;
    end else if (cfgLoad) begin
      nBrp <= clampVal(nomBrp, BRP_MIN, BRP_MAX); // see R14
      nTs1 <= clampVal(nomTseg1, NOM_TS1_MIN, NOM_TS1_MAX); // see R15
      nTs2 <= clampVal(nomTseg2, NOM_TS2_MIN, NOM_TS2_MAX);
      nSjw <= clampVal(nomSjw, NOM_SJW_MIN, NOM_SJW_MAX);
      dBrp <= clampVal(dataBrp, BRP_MIN, BRP_MAX); // see R16
      dTs1 <= clampVal(dataTseg1, DAT_TS1_MIN, DAT_TS1_MAX);
      dTs2 <= clampVal(dataTseg2, DAT_TS2_MIN, DAT_TS2_MAX);
      dSjw <= clampVal(dataSjw, DAT_SJW_MIN, DAT_SJW_MAX);
    end
  end

  // Receive FIFO occupancy; frame storage lives outside this block
  assign fifoCapacity   = capacityOf(depthCode); // see R3
  assign payloadBytes   = payloadOf(payCode); // see R4
  assign thresholdLevel = thresholdOf(fifoCapacity, threshCode); // see R1
  assign popOk          = rxPop && (fifoLevel != '0);
  assign accept         = rxFrame && fifoEn && (fifoLevel < fifoCapacity || popOk); // see R7
  assign next_level     = fifoLevel + CNT_W'(accept) - CNT_W'(popOk);

  always_ff @(posedge clock) begin
    if (rst) begin
      fifoLevel <= '0;
    end else if (!fifoEn) begin
      fifoLevel <= '0;
    end else begin
      fifoLevel <= next_level;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      frameAccepted <= 1'b0;
      frameDropped  <= 1'b0;
    end else begin
      frameAccepted <= accept;
      frameDropped  <= rxFrame && !accept; // see R7
    end
  end

  // A frame that lands exactly on the threshold is the crossing
  always_ff @(posedge clock) begin
    if (rst) begin
      fifoIrq <= 1'b0;
    end else begin
      unique case (irqMode)
        IRQ_OFF:       fifoIrq <= 1'b0; // see R5
        IRQ_THRESHOLD: fifoIrq <= accept && (fifoLevel + 6'h01 == thresholdLevel); // see R2, R6
        IRQ_EVERY:     fifoIrq <= accept; // see R5
        default:       fifoIrq <= 1'b0;
      endcase
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_TXMB; gi++) begin : g_txirq
      always_ff @(posedge clock) begin
        if (rst) begin
          txDoneIrq[gi] <= 1'b0;
        end else begin
          txDoneIrq[gi] <= txDone[gi] && txIrqEn[gi]; // see R8
        end
      end
    end
  endgenerate

  // Each error source passes only through its own enable
  always_ff @(posedge clock) begin
    if (rst) begin
      errorCause <= '0;
      errorIrq   <= 1'b0;
    end else begin
      errorCause <= errEvent & errIrqEn; // see R9, R10, R11, R12, R13
      errorIrq   <= |(errEvent & errIrqEn); // see R9, R10, R11, R12, R13
    end
  end

  bit_timing_if bt ();
  assign bt.brp    = dataPhase ? dBrp : nBrp;
  assign bt.tseg1  = dataPhase ? dTs1 : nTs1;
  assign bt.tseg2  = dataPhase ? dTs2 : nTs2;
  assign bt.sjw    = dataPhase ? dSjw : nSjw;
  assign bt.resync = resync;
  assign tqTick      = bt.tqTick;
  assign bitStart    = bt.bitStart;
  assign samplePoint = bt.samplePoint;

  bit_timer u_timer (
    .clock (clock),
    .rst   (rst),
    .bt    (bt.timer)
  );

  // Loop delay: cycles from a transmit edge to the same edge read back
  logic             txPrev;
  logic             tdcWait;
  logic             tdcLevel;
  logic [TIM_W-1:0] tdcCnt;
  logic [15:0]      sampleOffset;

  // Good only while the data prescaler stays small, as software must ensure
  assign sampleOffset = 16'(dTs1 + 11'h001) * 16'(dBrp); // see R18

  always_ff @(posedge clock) begin
    if (rst) begin
      txPrev <= 1'b1;
    end else begin
      txPrev <= txBit;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || !tdcEn || !dataPhase) begin
      tdcWait  <= 1'b0;
      tdcLevel <= 1'b1;
      tdcCnt   <= '0;
    end else if (!tdcWait && txBit != txPrev) begin
      tdcWait  <= 1'b1; // see R17
      tdcLevel <= txBit;
      tdcCnt   <= 11'h001;
    end else if (tdcWait && (rxBit == tdcLevel || tdcCnt == '1)) begin
      tdcWait  <= 1'b0;
    end else if (tdcWait) begin
      tdcCnt   <= tdcCnt + 11'h001;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || !tdcEn) begin
      tdcDelay     <= '0; // see R17
      tdcSamplePos <= '0;
    end else if (tdcWait && rxBit == tdcLevel) begin
      tdcDelay     <= tdcCnt; // see R17
      tdcSamplePos <= 16'(tdcCnt) + sampleOffset;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_fifo_reset_off:   assert property ($past(rst) |-> !fifoEn && irqMode == IRQ_EVERY && threshCode == THRESH_DEF) // see R7
    else $error("FIFO defaults wrong after reset");
  // Shrinking the depth may leave the level above capacity, so only growth is barred there
  a_fifo_no_over:     assert property (fifoLevel >= fifoCapacity && !popOk |=> fifoLevel <= $past(fifoLevel)) // see R3
    else $error("FIFO level above capacity");
  a_disabled_drops:   assert property (rxFrame && !fifoEn |=> frameDropped && !frameAccepted) // see R7
    else $error("Frame taken while FIFO disabled");
  a_every_frame_irq:  assert property (irqMode == IRQ_EVERY && accept |=> fifoIrq && fifoLevel != '0) // see R5
    else $error("Every frame mode missed interrupt");
  a_irq_off_quiet:    assert property (irqMode == IRQ_OFF |=> !fifoIrq) // see R5
    else $error("FIFO interrupt while off");
  a_thresh_cross:     assert property (irqMode == IRQ_THRESHOLD && rxFrame && fifoEn && !popOk
                                       && fifoLevel + 6'h01 == thresholdLevel |=> fifoIrq) // see R6
    else $error("Threshold crossing missed");
  a_thresh_only:      assert property (irqMode == IRQ_THRESHOLD && !(accept && fifoLevel + 6'h01 == thresholdLevel)
                                       |=> !fifoIrq) // see R2
    else $error("Threshold interrupt without crossing");
  a_half_default:     assert property (threshCode == THRESH_DEF |-> thresholdLevel == {1'b0, fifoCapacity[5:1]}) // see R1
    else $error("Default threshold not half");
  a_txirq_gate:       assert property (txDoneIrq != '0 |-> $past(txIrqEn) != '0 && $past(txDone) != '0) // see R8
    else $error("Transmit interrupt without enable");
  a_warn_irq:         assert property (errEvent[ERR_WARN] && errIrqEn[ERR_WARN] |=> errorIrq) // see R9
    else $error("Warning interrupt missed");
  a_err_masked:       assert property (errorIrq |-> $past(errEvent & errIrqEn) != '0) // see R10
    else $error("Error interrupt from a masked source");
  a_busoff_irq:       assert property (errEvent[ERR_BO_IN] && !errIrqEn[ERR_BO_IN] |=> !errorCause[ERR_BO_IN]) // see R11
    else $error("Bus-off entry leaked through mask");
  a_recover_irq:      assert property (errEvent[ERR_BO_OUT] && errIrqEn[ERR_BO_OUT] |=> errorCause[ERR_BO_OUT]) // see R12
    else $error("Bus-off recovery interrupt missed");
  a_ovld_irq:         assert property (errEvent[ERR_OVLD] && errIrqEn[ERR_OVLD] // see R13
                                       |=> errorIrq && errorCause[ERR_OVLD])
    else $error("Overload interrupt missed");
  a_brp_range:        assert property (nBrp >= BRP_MIN && nBrp <= BRP_MAX) // see R14
    else $error("Nominal prescaler out of range");
  a_nom_range:        assert property (nTs1 >= NOM_TS1_MIN && nTs1 <= NOM_TS1_MAX && nSjw <= NOM_SJW_MAX) // see R15
    else $error("Nominal segment out of range");
  a_data_range:       assert property (dTs2 >= DAT_TS2_MIN && dTs2 <= DAT_TS2_MAX && dBrp <= BRP_MAX) // see R16
    else $error("Data segment out of range");
  a_tdc_off_zero:     assert property (!tdcEn |=> tdcDelay == '0) // see R17
    else $error("Delay measured while compensation off");
  a_tq_gap:           assert property (bt.brp == 11'h002 && !resync && $stable(bt.brp) && tqTick // see R19
                                       |=> !tqTick ##1 (tqTick || $past(resync) || $past(bt.brp) != $past(bt.brp, 2)))
    else $error("Quantum spacing wrong");

  c_every_frame:  cover property (irqMode == IRQ_EVERY && fifoIrq);
  c_thresh_cross: cover property (irqMode == IRQ_THRESHOLD && fifoIrq);
  c_full_drop:    cover property (fifoEn && frameDropped);
  c_error_irq:    cover property (errorIrq);
  c_tdc_measure:  cover property (tdcDelay != '0);
endmodule

// ---- verification/can_bus_loop.sv ----
// Far side of the bus: echoes the transmitted bit back after a fixed loop delay
module can_bus_loop #(
  parameter int DELAY = 3
) (
  // Clock
  input  wire logic clock,
  // Bus bits
  input  wire logic txBit,
  output logic      rxBit
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [DELAY-1:0] wire_delay = '0;
  // Transceiver plus wiring delay that the compensation has to measure
  always @(posedge clock) wire_delay <= {wire_delay[DELAY-2:0], txBit};
  assign rxBit = wire_delay[DELAY-1];
endmodule

// ---- verification/canfd_rx_fifo_timing_config_tb_top.sv ----
// Self-checking bench for the receive FIFO, interrupt gating and delay compensation
module canfd_rx_fifo_timing_config_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import canfd_cfg_pkg::*;
  logic clock = 0, rst = 1, cfgLoad = 0, rxFifoEnable = 0, rxFifoIrqEnable = 1, rxFifoIrqEveryFrame = 1;
  logic [2:0] fifoDepthCode = 3'h3, payloadCode = 3'h7, fifoThresholdCode = 3'h3;
  logic [3:0] txDoneIrqEnable = 4'h0, txDone = 4'h0, txDoneIrq;
  logic warningIrqEnable = 0, passiveIrqEnable = 0, busoffEntryIrqEnable = 0, busoffRecoverIrqEnable = 0;
  logic overloadIrqEnable = 0, delayCompEnable = 1, rxFrame = 0, rxPop = 0, dataPhase = 0, resync = 0, txBit = 0;
  logic [10:0] nomBrp = 11'h001, nomTseg1 = 11'h014, nomTseg2 = 11'h00a, nomSjw = 11'h004, tdcDelay;
  logic [10:0] dataBrp = 11'h001, dataTseg1 = 11'h005, dataTseg2 = 11'h002, dataSjw = 11'h001;
  logic [4:0] errEvent = 5'h00, errorCause;
  logic [5:0] fifoLevel, fifoCapacity;
  logic [6:0] payloadBytes;
  logic [15:0] tdcSamplePos;
  logic rxBit, frameAccepted, frameDropped, fifoIrq, errorIrq, tqTick, bitStart, samplePoint;
  int fails = 0, totalChecks = 0, n = 0;
  logic [6:0] payTab [8] = '{7'h08, 7'h0c, 7'h10, 7'h14, 7'h18, 7'h20, 7'h30, 7'h40};
  logic [5:0] capTab [8] = '{6'h10, 6'h04, 6'h08, 6'h10, 6'h20, 6'h30, 6'h10, 6'h10};

  canfd_rx_fifo_timing_config canfd_rx_fifo_timing_config_inst (.clock, .rst, .cfgLoad, .rxFifoEnable,
    .fifoDepthCode, .payloadCode, .fifoThresholdCode, .rxFifoIrqEnable, .rxFifoIrqEveryFrame, .txDoneIrqEnable,
    .warningIrqEnable, .passiveIrqEnable, .busoffEntryIrqEnable, .busoffRecoverIrqEnable, .overloadIrqEnable,
    .nomBrp, .nomTseg1, .nomTseg2, .nomSjw, .dataBrp, .dataTseg1, .dataTseg2, .dataSjw, .delayCompEnable,
    .rxFrame, .rxPop, .txDone, .errEvent, .dataPhase, .resync, .txBit, .rxBit, .fifoLevel, .fifoCapacity,
    .payloadBytes, .frameAccepted, .frameDropped, .fifoIrq, .txDoneIrq, .errorIrq, .errorCause,
    .tqTick, .bitStart, .samplePoint, .tdcDelay, .tdcSamplePos);
  can_bus_loop #(.DELAY(3)) can_bus_loop_inst (.clock, .txBit, .rxBit);

  always #20 clock = ~clock;

  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    totalChecks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  // One load of the configuration; the edge that lowers cfgLoad is the capture edge
  task automatic cfg(input logic en, input logic [2:0] dep, pay, thr, input logic [1:0] md,
                     input logic [3:0] txe, input logic [4:0] ee, input logic [10:0] dbrp);
    @(posedge clock) cfgLoad <= 1'b1;
    {rxFifoEnable, fifoDepthCode, payloadCode, fifoThresholdCode, rxFifoIrqEnable, rxFifoIrqEveryFrame} <= {en, dep, pay, thr, md};
    {overloadIrqEnable, busoffRecoverIrqEnable, busoffEntryIrqEnable, passiveIrqEnable, warningIrqEnable} <= ee;
    txDoneIrqEnable <= txe;
    dataBrp <= dbrp;
    @(posedge clock) cfgLoad <= 1'b0;
    #1;
  endtask

  task automatic frame(input logic acc, input logic irq);
    @(posedge clock) rxFrame <= 1'b1;
    @(posedge clock) rxFrame <= 1'b0;
    #1 chk("frameAccepted", acc, frameAccepted);
    chk("frameDropped", !acc, frameDropped);
    chk("fifoIrq", irq, fifoIrq);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clock);
    fails++;
    results();
  end

  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    #1 chk("fifoCapacity", 16'h10, fifoCapacity);
    chk("payloadBytes", 16'h40, payloadBytes);
    // Nominal defaults at prescaler 1: sample point 1+20 quanta into the bit, bit 31 quanta
    do @(posedge clock) #1; while (!bitStart);
    n = 0;
    do begin @(posedge clock) #1 n++; end while (!samplePoint);
    chk("samplePoint", 16'h0015, 16'(n));
    chk("tqTick", 16'h0001, tqTick);
    do begin @(posedge clock) #1 n++; end while (!bitStart);
    chk("bitStart", 16'h001f, 16'(n));
    $display("test bit timing done");
    frame(1'b0, 1'b0);
    for (int c = 0; c < 8; c++) begin
      cfg(1'b0, c[2:0], c[2:0], 3'h3, 2'b11, 4'h0, 5'h00, 11'h001);
      chk("fifoCapacity", capTab[c], fifoCapacity);
      chk("payloadBytes", payTab[c], payloadBytes);
    end
    $display("test codes done");
    // Threshold code 0 would fire only on the first frame, so the second shows it is ignored
    cfg(1'b1, 3'h1, 3'h7, 3'h0, 2'b11, 4'h0, 5'h00, 11'h001);
    frame(1'b1, 1'b1);
    frame(1'b1, 1'b1);
    cfg(1'b0, 3'h1, 3'h7, 3'h3, 2'b10, 4'h0, 5'h00, 11'h001);
    cfg(1'b1, 3'h1, 3'h7, 3'h3, 2'b10, 4'h0, 5'h00, 11'h001);
    frame(1'b1, 1'b0);
    frame(1'b1, 1'b1);
    frame(1'b1, 1'b0);
    frame(1'b1, 1'b0);
    frame(1'b0, 1'b0);
    chk("fifoLevel", 16'h04, fifoLevel);
    cfg(1'b1, 3'h1, 3'h7, 3'h3, 2'b01, 4'h0, 5'h00, 11'h001);
    @(posedge clock) rxPop <= 1'b1;
    @(posedge clock) rxPop <= 1'b0;
    frame(1'b1, 1'b0);
    $display("test fifo done");
    cfg(1'b1, 3'h1, 3'h7, 3'h3, 2'b00, 4'h5, 5'h00, 11'h001);
    @(posedge clock) txDone <= 4'hf;
    @(posedge clock) txDone <= 4'h0;
    #1 chk("txDoneIrq", 16'h5, txDoneIrq);
    for (int k = 0; k < 6; k++) begin
      cfg(1'b1, 3'h1, 3'h7, 3'h3, 2'b00, 4'h0, 5'(1 << k) & 5'h1f, 11'h001);
      @(posedge clock) errEvent <= 5'h1f;
      @(posedge clock) errEvent <= 5'h00;
      #1 chk("errorCause", 16'((1 << k) & 5'h1f), errorCause);
      chk("errorIrq", {15'h0, k < 5}, errorIrq);
    end
    $display("test interrupts done");
    // Data prescaler stays at 2 with compensation on
    cfg(1'b1, 3'h3, 3'h7, 3'h3, 2'b11, 4'h0, 5'h00, 11'h002);
    @(posedge clock) dataPhase <= 1'b1;
    @(posedge clock) txBit <= 1'b1;
    repeat (10) @(posedge clock);
    #1 chk("tdcDelay", 16'h3, tdcDelay);
    chk("tdcSamplePos", 16'h000f, tdcSamplePos);
    // Switching compensation off must clear the measured delay
    @(posedge clock) delayCompEnable <= 1'b0;
    cfg(1'b1, 3'h3, 3'h7, 3'h3, 2'b11, 4'h0, 5'h00, 11'h002);
    @(posedge clock) #1 chk("tdcDelay", 16'h0, tdcDelay);
    $display("test delay compensation done");
    results();
  end
endmodule
